// ==== card_pwr_ctl.sv ====
// Serial control, protection and status logic of a dual-slot card power switch
//
// The address-and-strobe port and the register offsets are this design's own decisions.
module card_pwr_ctl
    import card_pwr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              ser_data_i,
    input  wire logic              ser_clk_i,
    input  wire logic              ser_latch_i,
    input  wire logic [OUT_NUM-1:0] over_cur_i,
    input  wire logic              thermal_trip_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    output vcc_state_e             slot_a_card_power_out_o,
    output vpp_state_e             slot_a_prog_power_out_o,
    output vcc_state_e             slot_b_card_power_out_o,
    output vpp_state_e             slot_b_prog_power_out_o,
    output logic      [OUT_NUM-1:0] cur_limit_o,
    output logic                   overcurrent_flag_n_o,
    output logic                   low_power_o,
    output logic                   irq_o
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 3 + OUT_NUM + 1;

    logic [SYNC_W-1:0] sync_s;
    logic              data_s;
    logic              sclk_s;
    logic              latch_s;
    logic [OUT_NUM-1:0] over_cur_s;
    logic              therm_s;

    sync2 #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({thermal_trip_i, over_cur_i, ser_latch_i, ser_clk_i, ser_data_i}),
        .sync_o    (sync_s)
    );

    assign data_s  = sync_s[0];
    assign sclk_s  = sync_s[1];
    assign latch_s = sync_s[2];
    assign over_cur_s = sync_s[3 +: OUT_NUM];
    assign therm_s = sync_s[SYNC_W-1];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic               sclk_prev;
        logic               latch_prev;
        logic               therm_prev;
        logic               over_cur_prev;
        logic [WORD_W-1:0]  shift;
        logic [WORD_W-1:0]  word;
        vcc_state_e         a_vcc;
        vpp_state_e         a_vpp;
        vcc_state_e         b_vcc;
        vpp_state_e         b_vpp;
        logic [OUT_NUM-1:0] cur_limit;
        logic               flag_n;
        logic               low_power;
        logic [EVT_W-1:0]   status;
        logic [EVT_W-1:0]   enable;
        logic               irq;
        logic [DATA_W-1:0]  rdata;
    } state_s;

    state_s q;
    state_s d;

    // ------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------
    logic       off;
    vcc_state_e a_vcc_dec;
    vpp_state_e a_vpp_dec;
    vcc_state_e b_vcc_dec;
    vpp_state_e b_vpp_dec;

    // Thermal trip and shutdown both float every output of both slots
    assign off = !q.word[POWER_DOWN_N_BIT] || therm_s;

    slot_decode u_slot_a (
        .off_i      (off),
        .vcc_3v_i   (q.word[SLOT_A_VCC_3V_BIT]),
        .vcc_5v_i   (q.word[SLOT_A_VCC_5V_BIT]),
        .vpp_prog_i (q.word[SLOT_A_PROG_VOLT_SEL]),
        .vpp_vcc_i  (q.word[SLOT_A_VPP_VCC_BIT]),
        .vcc_o      (a_vcc_dec),
        .vpp_o      (a_vpp_dec)
    );

    slot_decode u_slot_b (
        .off_i      (off),
        .vcc_3v_i   (q.word[SLOT_B_VCC_3V_BIT]),
        .vcc_5v_i   (q.word[SLOT_B_VCC_5V_BIT]),
        .vpp_prog_i (q.word[SLOT_B_PROG_VOLT_SEL]),
        .vpp_vcc_i  (q.word[SLOT_B_VPP_VCC_BIT]),
        .vcc_o      (b_vcc_dec),
        .vpp_o      (b_vpp_dec)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic             sclk_rise;
    logic             latch_rise;
    logic [EVT_W-1:0] events;

    always_comb begin
        sclk_rise  = sclk_s && !q.sclk_prev;
        latch_rise = latch_s && !q.latch_prev;

        events                = '0;
        events[EVT_LATCHED]   = latch_rise;
        events[EVT_OVERCUR]   = (|over_cur_s) && !q.over_cur_prev;
        events[EVT_THERM_ON]  = therm_s && !q.therm_prev;
        events[EVT_THERM_OFF] = !therm_s && q.therm_prev;

        d             = q;
        d.sclk_prev   = sclk_s;
        d.latch_prev  = latch_s;
        d.therm_prev  = therm_s;
        d.over_cur_prev = |over_cur_s;

        // First of the last WORD_W bits shifted in ends up in the top bit; earlier bits are shifted out
        if (sclk_rise) begin
            d.shift = {q.shift[WORD_W-2:0], data_s};
        end
        // A clock rise in the same cycle is not folded in; the controller keeps them apart
        if (latch_rise) begin
            d.word = q.shift;
        end

        d.a_vcc = a_vcc_dec;
        d.a_vpp = a_vpp_dec;
        d.b_vcc = b_vcc_dec;
        d.b_vpp = b_vpp_dec;

        // Limiting never changes the commanded state, only clamps the sensed output
        d.cur_limit = off ? '0 : over_cur_s;
        d.flag_n    = !(|over_cur_s);
        d.low_power = !q.word[POWER_DOWN_N_BIT];

        // Set wins over a clear in the same cycle
        d.status = q.status;
        if (reg_wr_i && reg_addr_i == REG_CLEAR) begin
            d.status = q.status & ~reg_wdata_i[EVT_W-1:0];
        end
        d.status = d.status | events;
        if (reg_wr_i && reg_addr_i == REG_ENABLE) begin
            d.enable = reg_wdata_i[EVT_W-1:0];
        end
        d.irq = |(q.status & q.enable);

        d.rdata = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_STATUS: d.rdata = {{(DATA_W-EVT_W){1'b0}}, q.status};
                REG_ENABLE: d.rdata = {{(DATA_W-EVT_W){1'b0}}, q.enable};
                REG_WORD:   d.rdata = {{(DATA_W-WORD_W){1'b0}}, q.word};
                REG_LIVE:   d.rdata = {{(DATA_W-OUT_NUM-2){1'b0}}, off, therm_s, over_cur_s};
                default:    d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q           <= '0;
            q.word      <= WORD_RST;
            q.a_vcc     <= VCC_HIZ;
            q.a_vpp     <= VPP_HIZ;
            q.b_vcc     <= VCC_HIZ;
            q.b_vpp     <= VPP_HIZ;
            q.flag_n    <= 1'b1;
            q.low_power <= 1'b1;
            q.enable    <= ENABLE_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_o             = q.rdata;
    assign slot_a_card_power_out_o = q.a_vcc;
    assign slot_a_prog_power_out_o = q.a_vpp;
    assign slot_b_card_power_out_o = q.b_vcc;
    assign slot_b_prog_power_out_o = q.b_vpp;
    assign cur_limit_o             = q.cur_limit;
    assign overcurrent_flag_n_o    = q.flag_n;
    assign low_power_o             = q.low_power;
    assign irq_o                   = q.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_shift_in;
        sclk_s && !q.sclk_prev |=> q.shift == {$past(q.shift[WORD_W-2:0]), $past(data_s)};
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted on clock rise");

    property p_latch_load;
        latch_s && !q.latch_prev |=> q.word == $past(q.shift) ##1 q.word == $past(q.shift, 2);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("word not loaded on latch rise");

    property p_latch_event;
        latch_s && !q.latch_prev |=> q.status[EVT_LATCHED];
    endproperty
    a_latch_event: assert property (p_latch_event) else $error("latch event not recorded");

    property p_shutdown;
        !q.word[POWER_DOWN_N_BIT] |=> slot_a_card_power_out_o == VCC_HIZ && slot_b_card_power_out_o == VCC_HIZ
            && slot_a_prog_power_out_o == VPP_HIZ && slot_b_prog_power_out_o == VPP_HIZ && low_power_o;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown did not float outputs");

    property p_low_power;
        q.word[POWER_DOWN_N_BIT] |=> !low_power_o;
    endproperty
    a_low_power: assert property (p_low_power) else $error("low power without shutdown");

    property p_flag;
        (|over_cur_s) |=> !overcurrent_flag_n_o;
    endproperty
    a_flag: assert property (p_flag) else $error("overcurrent flag not low");

    property p_flag_clear;
        !(|over_cur_s) |=> overcurrent_flag_n_o;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("overcurrent flag low without cause");

    property p_limit_one;
        over_cur_s == 4'h1 && !off |=> cur_limit_o == 4'h1;
    endproperty
    a_limit_one: assert property (p_limit_one) else $error("limit reached a healthy output");

    property p_thermal;
        therm_s |=> slot_a_card_power_out_o == VCC_HIZ && slot_b_card_power_out_o == VCC_HIZ
            && slot_a_prog_power_out_o == VPP_HIZ && slot_b_prog_power_out_o == VPP_HIZ;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal trip left an output on");

    property p_limit_off;
        off |=> cur_limit_o == 4'h0;
    endproperty
    a_limit_off: assert property (p_limit_off) else $error("limit shown on a floated output");

    property p_no_cutoff;
        $changed(over_cur_s) && $stable(q.word) && !therm_s && !$past(therm_s)
            |=> $stable(slot_a_card_power_out_o) && $stable(slot_b_card_power_out_o);
    endproperty
    a_no_cutoff: assert property (p_no_cutoff) else $error("overcurrent changed an output state");

    // Decode checks below: off already folds in shutdown and thermal trip
    property p_ground;
        !off && q.word[SLOT_A_VCC_5V_BIT] && q.word[SLOT_A_VCC_3V_BIT] |=> slot_a_card_power_out_o == VCC_GND;
    endproperty
    a_ground: assert property (p_ground) else $error("slot A supply not grounded");

    property p_b_ground;
        !off && !q.word[SLOT_B_VCC_5V_BIT] && !q.word[SLOT_B_VCC_3V_BIT] |=> slot_b_card_power_out_o == VCC_GND;
    endproperty
    a_b_ground: assert property (p_b_ground) else $error("slot B supply not grounded");

    property p_a_vpp_ground;
        !off && !q.word[SLOT_A_PROG_VOLT_SEL] && !q.word[SLOT_A_VPP_VCC_BIT] |=> slot_a_prog_power_out_o == VPP_GND;
    endproperty
    a_a_vpp_ground: assert property (p_a_vpp_ground) else $error("slot A programming not grounded");

    property p_a_12v;
        !off && q.word[SLOT_A_PROG_VOLT_SEL] && !q.word[SLOT_A_VPP_VCC_BIT] |=> slot_a_prog_power_out_o == VPP_12V;
    endproperty
    a_a_12v: assert property (p_a_12v) else $error("slot A programming output not 12 V");

    property p_a_follow;
        !off && !q.word[SLOT_A_PROG_VOLT_SEL] && q.word[SLOT_A_VPP_VCC_BIT] |=> slot_a_prog_power_out_o == VPP_VCC;
    endproperty
    a_a_follow: assert property (p_a_follow) else $error("slot A programming not following");

    property p_b_follow;
        !off && !q.word[SLOT_B_PROG_VOLT_SEL] && q.word[SLOT_B_VPP_VCC_BIT] |=> slot_b_prog_power_out_o == VPP_VCC;
    endproperty
    a_b_follow: assert property (p_b_follow) else $error("slot B programming output not following");

    property p_b_12v;
        !off && q.word[SLOT_B_PROG_VOLT_SEL] && !q.word[SLOT_B_VPP_VCC_BIT] |=> slot_b_prog_power_out_o == VPP_12V;
    endproperty
    a_b_12v: assert property (p_b_12v) else $error("slot B programming output not 12 V");

    property p_b_hiz;
        !off && q.word[SLOT_B_PROG_VOLT_SEL] && q.word[SLOT_B_VPP_VCC_BIT] |=> slot_b_prog_power_out_o == VPP_HIZ;
    endproperty
    a_b_hiz: assert property (p_b_hiz) else $error("slot B programming output not floating");

    property p_a_3v;
        !off && !q.word[SLOT_A_VCC_5V_BIT] && q.word[SLOT_A_VCC_3V_BIT] |=> slot_a_card_power_out_o == VCC_3V;
    endproperty
    a_a_3v: assert property (p_a_3v) else $error("slot A supply not 3 V");

    property p_a_5v;
        !off && q.word[SLOT_A_VCC_5V_BIT] && !q.word[SLOT_A_VCC_3V_BIT] |=> slot_a_card_power_out_o == VCC_5V;
    endproperty
    a_a_5v: assert property (p_a_5v) else $error("slot A supply not 5 V");

    property p_b_3v;
        !off && !q.word[SLOT_B_VCC_5V_BIT] && q.word[SLOT_B_VCC_3V_BIT] |=> slot_b_card_power_out_o == VCC_3V;
    endproperty
    a_b_3v: assert property (p_b_3v) else $error("slot B supply not 3 V");

    property p_b_5v;
        !off && q.word[SLOT_B_VCC_5V_BIT] && !q.word[SLOT_B_VCC_3V_BIT] |=> slot_b_card_power_out_o == VCC_5V;
    endproperty
    a_b_5v: assert property (p_b_5v) else $error("slot B supply not 5 V");

endmodule : card_pwr_ctl

// ==== card_pwr_pkg.sv ====
// Shared constants and types of the dual-slot card power control block
package card_pwr_pkg;

    // ------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------
    localparam int WORD_W               = 9;
    localparam int SLOT_A_PROG_VOLT_SEL = 0;
    localparam int SLOT_A_VPP_VCC_BIT   = 1;
    localparam int SLOT_A_VCC_3V_BIT    = 2;
    localparam int SLOT_A_VCC_5V_BIT    = 3;
    localparam int SLOT_B_PROG_VOLT_SEL = 4;
    localparam int SLOT_B_VPP_VCC_BIT   = 5;
    localparam int SLOT_B_VCC_5V_BIT    = 6;
    localparam int SLOT_B_VCC_3V_BIT    = 7;
    localparam int POWER_DOWN_N_BIT     = 8;
    localparam logic [WORD_W-1:0] WORD_RST = 9'h000;

    // ------------------------------------------------------------
    // Sense inputs, one per power output
    // ------------------------------------------------------------
    localparam int OUT_NUM   = 4;
    localparam int OUT_A_VCC = 0;
    localparam int OUT_A_VPP = 1;
    localparam int OUT_B_VCC = 2;
    localparam int OUT_B_VPP = 3;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CLEAR   = 4'h1;
    localparam logic [ADDR_W-1:0] REG_ENABLE  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_WORD    = 4'h3;
    localparam logic [ADDR_W-1:0] REG_LIVE    = 4'h4;

    // Event bits of status, clear and enable
    localparam int EVT_W         = 4;
    localparam int EVT_LATCHED   = 0;
    localparam int EVT_OVERCUR   = 1;
    localparam int EVT_THERM_ON  = 2;
    localparam int EVT_THERM_OFF = 3;
    localparam logic [EVT_W-1:0] ENABLE_RST = 4'h0;

    // ------------------------------------------------------------
    // Output states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {VCC_GND, VCC_3V, VCC_5V, VCC_HIZ} vcc_state_e;
    typedef enum logic [1:0] {VPP_GND, VPP_VCC, VPP_12V, VPP_HIZ} vpp_state_e;

endpackage : card_pwr_pkg

// ==== ser_link_model.sv ====
// Behavioural card slot controller driving the three-lead serial link
module ser_link_model (
    output logic ser_data_o,
    output logic ser_clk_o,
    output logic ser_latch_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ser_data_o  = 1'b0;
        ser_clk_o   = 1'b0;
        ser_latch_o = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame: oldest bit first, clock stands low outside frames
    // ------------------------------------------------------------
    task automatic send_bits(input logic [15:0] bits, input int n, input int half_ns);
        for (int i = n - 1; i >= 0; i--) begin
            ser_data_o = bits[i];
            #(half_ns);
            ser_clk_o  = 1'b1;
            #(half_ns);
            ser_clk_o  = 1'b0;
        end
        ser_latch_o = 1'b1;
        #(half_ns);
        ser_latch_o = 1'b0;
        // Released lead flips so a stale bit never looks fresh
        ser_data_o  = ~ser_data_o;
        #(half_ns);
    endtask : send_bits
endmodule : ser_link_model

// ==== slot_decode.sv ====
// Combinational decode of one slot's control bits into output states
module slot_decode
    import card_pwr_pkg::*;
(
    input  wire logic       off_i,
    input  wire logic       vcc_3v_i,
    input  wire logic       vcc_5v_i,
    input  wire logic       vpp_prog_i,
    input  wire logic       vpp_vcc_i,
    output vcc_state_e      vcc_o,
    output vpp_state_e      vpp_o
);
    always_comb begin
        if (off_i) begin
            vcc_o = VCC_HIZ;
            vpp_o = VPP_HIZ;
        end else begin
            // Both select bits set falls back to ground, never to a voltage
            unique case ({vcc_5v_i, vcc_3v_i})
                2'b01:   vcc_o = VCC_3V;
                2'b10:   vcc_o = VCC_5V;
                default: vcc_o = VCC_GND;
            endcase
            unique case ({vpp_prog_i, vpp_vcc_i})
                2'b00:   vpp_o = VPP_GND;
                2'b01:   vpp_o = VPP_VCC;
                2'b10:   vpp_o = VPP_12V;
                default: vpp_o = VPP_HIZ;
            endcase
        end
    end

endmodule : slot_decode

// ==== sync2.sv ====
// Two-flop synchroniser for a group of asynchronous levels
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s q;
    sync_s d;

    always_comb begin
        d.first  = async_i;
        d.second = q.first;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.second;

endmodule : sync2

// ==== tb_card_pwr_ctl.sv ====
// Self-checking testbench of the dual-slot card power control block
module tb_card_pwr_ctl;
    timeunit 1ns;
    timeprecision 1ps;
    import card_pwr_pkg::*;

    logic               clk_i = 1'b0;
    logic               sys_rst_i = 1'b1;
    logic               ser_data, ser_clk, ser_latch;
    logic [OUT_NUM-1:0] over_cur_i = 4'h0;
    logic               thermal_trip_i = 1'b0;
    logic [ADDR_W-1:0]  reg_addr_i = 4'h0;
    logic [DATA_W-1:0]  reg_wdata_i = 16'h0000;
    logic               reg_wr_i = 1'b0;
    logic               reg_rd_i = 1'b0;
    logic [DATA_W-1:0]  reg_rdata_o;
    vcc_state_e         a_vcc, b_vcc;
    vpp_state_e         a_vpp, b_vpp;
    logic [OUT_NUM-1:0] cur_limit_o;
    logic               flag_n, low_power, irq;
    int                 errors = 0;
    int                 comparisons = 0;
    int                 seed = 32'hea70060f;
    logic [3:0]         en = 4'h0;
    logic [8:0]         w;

    always #20 clk_i = ~clk_i;

    ser_link_model u_link (.ser_data_o(ser_data), .ser_clk_o(ser_clk), .ser_latch_o(ser_latch));

    card_pwr_ctl u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ser_data_i(ser_data), .ser_clk_i(ser_clk),
        .ser_latch_i(ser_latch), .over_cur_i(over_cur_i), .thermal_trip_i(thermal_trip_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .slot_a_card_power_out_o(a_vcc),
        .slot_a_prog_power_out_o(a_vpp), .slot_b_card_power_out_o(b_vcc),
        .slot_b_prog_power_out_o(b_vpp), .cur_limit_o(cur_limit_o),
        .overcurrent_flag_n_o(flag_n), .low_power_o(low_power), .irq_o(irq)
    );

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        check(nm, e, reg_rdata_o);
    endtask : reg_read

    // Reference decode: pairs of bits give the state code directly for the programming outputs
    function automatic logic [7:0] exp_out(input logic [8:0] x, input logic off);
        logic [1:0] av;
        logic [1:0] bv;
        av = ({x[3], x[2]} == 2'h1) ? 2'h1 : ({x[3], x[2]} == 2'h2) ? 2'h2 : 2'h0;
        bv = ({x[6], x[7]} == 2'h1) ? 2'h1 : ({x[6], x[7]} == 2'h2) ? 2'h2 : 2'h0;
        if (off || !x[8]) begin
            return 8'hFF;
        end
        return {av, x[0], x[1], bv, x[4], x[5]};
    endfunction : exp_out

    task automatic check_outs(input logic [8:0] x, input logic off);
        check("power_outs", {8'h00, exp_out(x, off)}, {8'h00, a_vcc, a_vpp, b_vcc, b_vpp});
    endtask : check_outs

    task automatic clear_all();
        reg_write(REG_CLEAR, 16'h000F);
        repeat (3) @(posedge clk_i);
        #1;
        check("irq_cleared", 16'h0000, {15'h0, irq});
    endtask : clear_all

    // One frame, then outputs, word register, event and interrupt
    task automatic apply(input logic [15:0] bits, input int n, input int half_ns);
        u_link.send_bits(bits, n, half_ns);
        @(posedge clk_i);
        #1;
        check_outs(bits[8:0], 1'b0);
        check("low_power", {15'h0, ~bits[8]}, {15'h0, low_power});
        check("irq_latch", {15'h0, en[0]}, {15'h0, irq});
        reg_read(REG_WORD, {7'h00, bits[8:0]}, "word");
        reg_read(REG_STATUS, 16'h0001, "status_latch");
        clear_all();
    endtask : apply

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check_outs(WORD_RST, 1'b0);
        check("flag_idle", 16'h0001, {15'h0, flag_n});
        reg_read(REG_ENABLE, 16'h0000, "enable_rst");
        en = 4'hF;
        reg_write(REG_ENABLE, 16'h000F);
        for (int i = 0; i < 28; i++) begin
            w = (i < 16) ? {1'b1, i[3:0], i[3:0]} : 9'($random(seed));
            apply({7'h00, w}, 9, 160);
        end
        // Mixed-voltage card: 5 V, discharge, then 3 V
        apply(16'h0108, 9, 160);
        apply(16'h0100, 9, 160);
        apply(16'h0104, 9, 160);
        apply(16'h07C5, 11, 160);
        en = 4'hE;
        reg_write(REG_ENABLE, 16'h000E);
        apply(16'h0159, 9, 160);
        for (int k = 0; k < OUT_NUM; k++) begin
            @(posedge clk_i);
            over_cur_i <= 4'(1 << k);
            repeat (5) @(posedge clk_i);
            #1;
            check("flag_over", 16'h0000, {15'h0, flag_n});
            check("cur_limit", 16'(1 << k), {12'h0, cur_limit_o});
            check("irq_over", 16'h0001, {15'h0, irq});
            check_outs(9'h159, 1'b0);
            reg_read(REG_LIVE, 16'(1 << k), "live_over");
            reg_read(REG_STATUS, 16'h0002, "status_over");
            @(posedge clk_i);
            over_cur_i <= 4'h0;
            clear_all();
            check("flag_clear", 16'h0001, {15'h0, flag_n});
        end
        @(posedge clk_i);
        thermal_trip_i <= 1'b1;
        over_cur_i     <= 4'h5;
        repeat (5) @(posedge clk_i);
        #1;
        check_outs(9'h159, 1'b1);
        check("cur_limit_off", 16'h0000, {12'h0, cur_limit_o});
        reg_read(REG_LIVE, 16'h0035, "live_therm");
        @(posedge clk_i);
        thermal_trip_i <= 1'b0;
        over_cur_i     <= 4'h0;
        repeat (5) @(posedge clk_i);
        #1;
        check_outs(9'h159, 1'b0);
        reg_read(REG_STATUS, 16'h000E, "status_therm");
        clear_all();
        reg_write(REG_WORD, 16'h0000);
        reg_write(REG_STATUS, 16'h000F);
        reg_read(REG_WORD, 16'h0159, "word_ro");
        reg_read(REG_STATUS, 16'h0000, "status_ro");
        reg_read(REG_CLEAR, 16'h0000, "clear_wo");
        reg_read(4'hF, 16'h0000, "unmapped");
        print_verdict();
    end

    initial begin
        #2000000;
        errors++;
        print_verdict();
    end
endmodule : tb_card_pwr_ctl
